//--- logic/mtb_timer_block.sv
/*
  Timer block: two classic byte-pair timers with four modes and a long
  timer stepped by a slow clock, reached over the special-function-
  register bus. Assumes a single-cycle bus write strobe and a read strobe
  whose data is returned one clock later; the slow clocks arrive as
  asynchronous pins and are much slower than the system clock.
*/
`timescale 1ns/100ps

module mtb_timer_block #(
  parameter int P_STEP_EDGES = mtb_pkg::LT_STEP_EDGES
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Register bus
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_sfr_rd,
  output logic      [7:0] o_sfr_rdata,
  // Slow clock pins
  input  wire logic       i_slow_rc_source,
  input  wire logic       i_watch_crystal_source,
  // Event levels
  output logic            o_t0_overflow_flag,
  output logic            o_t1_overflow_flag,
  output logic            o_long_timer_irq_flag
);

  mtb_pkg::mtb_state_t st;
  mtb_pkg::mtb_state_t next_st;

  // One count step of a classic timer in the given mode
  function automatic mtb_pkg::mtb_step_t tmr_step(
    input mtb_pkg::mtb_mode_t mode,
    input logic [7:0]         low,
    input logic [7:0]         high
  );
    mtb_pkg::mtb_step_t r;
    logic [12:0]        v13;
    logic [16:0]        v16;
    r    = '{ovf: 1'b0, low: low, high: high};
    v13  = {high, low[4:0]} + 13'h0001;
    v16  = {1'b0, high, low} + 17'h0_0001;
    unique case (mode)
      mtb_pkg::MODE_13BIT: begin
        r.ovf  = &{high, low[4:0]};
        r.low  = {low[7:5], v13[4:0]};
        r.high = v13[12:5];
      end
      mtb_pkg::MODE_16BIT: begin
        r.ovf  = v16[16];
        r.low  = v16[7:0];
        r.high = v16[15:8];
      end
      mtb_pkg::MODE_RELOAD8: begin
        r.ovf = &low;
        r.low = (&low) ? high : low + 8'h01;
      end
      mtb_pkg::MODE_SPLIT8: begin
        r.ovf = &low;
        r.low = low + 8'h01;
      end
    endcase
    return r;
  endfunction

  // Bus strobes per register
  logic wr_run, wr_mode, wr_c0l, wr_c0h, wr_c1l, wr_c1h;
  logic wr_stat, wr_cfg, wr_tgt_h, wr_tgt_l;

  always_comb begin
    wr_run   = i_sfr_wr && (i_sfr_addr == mtb_pkg::OFS_RUN_FLAGS);
    wr_mode  = i_sfr_wr && (i_sfr_addr == mtb_pkg::OFS_MODE_SELECT);
    wr_c0l   = i_sfr_wr && (i_sfr_addr == mtb_pkg::OFS_CNT0_LOW);
    wr_c0h   = i_sfr_wr && (i_sfr_addr == mtb_pkg::OFS_CNT0_HIGH);
    wr_c1l   = i_sfr_wr && (i_sfr_addr == mtb_pkg::OFS_CNT1_LOW);
    wr_c1h   = i_sfr_wr && (i_sfr_addr == mtb_pkg::OFS_CNT1_HIGH);
    wr_stat  = i_sfr_wr && (i_sfr_addr == mtb_pkg::OFS_IRQ_STATUS);
    wr_cfg   = i_sfr_wr && (i_sfr_addr == mtb_pkg::OFS_LT_CONFIG);
    wr_tgt_h = i_sfr_wr && (i_sfr_addr == mtb_pkg::OFS_LT_TGT_HIGH);
    wr_tgt_l = i_sfr_wr && (i_sfr_addr == mtb_pkg::OFS_LT_TGT_LOW);
  end

  // Classic timer stepping and flag setting
  mtb_pkg::mtb_step_t s0, s1;
  logic               t0_split, t0_go, t1_go, hi0_go, hi0_ovf;
  logic               set_ovf0, set_ovf1;

  always_comb begin
    t0_split = (st.timer0_mode_field == mtb_pkg::MODE_SPLIT8);
    t0_go    = st.t0_run_bit;
    // Timer 1 free-runs with no flag while timer 0 owns its run bit
    t1_go    = (st.timer1_mode_field != mtb_pkg::MODE_SPLIT8)
               && (t0_split || st.t1_run_bit);
    hi0_go   = t0_split && st.t1_run_bit;
    s0       = tmr_step(st.timer0_mode_field, st.cnt0_low,
                        st.cnt0_high);
    s1       = tmr_step(st.timer1_mode_field, st.cnt1_low,
                        st.cnt1_high);
    hi0_ovf  = hi0_go && (&st.cnt0_high);
    set_ovf0 = t0_go && s0.ovf;
    set_ovf1 = (t1_go && s1.ovf && !t0_split) || hi0_ovf;
  end

  // Slow clock edge detection and long timer step
  logic rc_rise, xt_rise, slow_tick, lt_step, lt_done, lt_restart;
  logic [15:0] lt_target;

  always_comb begin
    rc_rise    = (st.sync_rc[1] == st.sync_rc[2]) && st.sync_rc[2]
                 && !st.stable_rc;
    xt_rise    = (st.sync_watch_crystal_source[1] == st.sync_watch_crystal_source[2]) && st.sync_watch_crystal_source[2]
                 && !st.stable_watch_crystal_source;
    slow_tick  = st.long_timer_clock_choice ? xt_rise : rc_rise;
    lt_target  = {st.long_timer_target_high, st.long_timer_target_low};
    lt_step    = st.long_timer_enable && slow_tick
                 && (!st.long_timer_step_mode
                     || (st.lt_prescale
                         == 16'(P_STEP_EDGES - 1)));
    lt_done    = lt_step && (st.lt_count == lt_target);
    lt_restart = (wr_cfg && i_sfr_wdata[mtb_pkg::BIT_LT_ENABLE])
                 || ((wr_tgt_h || wr_tgt_l)
                     && st.long_timer_enable);
  end

  // Next state
  always_comb begin
    next_st = st;

    // Pin synchronisers, first stage feeds only the second
    next_st.sync_rc   = {st.sync_rc[1:0], i_slow_rc_source};
    next_st.sync_watch_crystal_source = {st.sync_watch_crystal_source[1:0], i_watch_crystal_source};
    if (st.sync_rc[1] == st.sync_rc[2]) begin
      next_st.stable_rc = st.sync_rc[2];
    end
    if (st.sync_watch_crystal_source[1] == st.sync_watch_crystal_source[2]) begin
      next_st.stable_watch_crystal_source = st.sync_watch_crystal_source[2];
    end

    // Timer 0 counting, software byte writes win over the count
    if (t0_go) begin
      next_st.cnt0_low = s0.low;
      if (!t0_split) begin
        next_st.cnt0_high = s0.high;
      end
    end
    if (hi0_go) begin
      next_st.cnt0_high = st.cnt0_high + 8'h01;
    end
    if (wr_c0l) begin
      next_st.cnt0_low = i_sfr_wdata;
    end
    if (wr_c0h) begin
      next_st.cnt0_high = i_sfr_wdata;
    end

    // Timer 1 counting
    if (t1_go) begin
      next_st.cnt1_low  = s1.low;
      next_st.cnt1_high = s1.high;
    end
    if (wr_c1l) begin
      next_st.cnt1_low = i_sfr_wdata;
    end
    if (wr_c1h) begin
      next_st.cnt1_high = i_sfr_wdata;
    end

    // Run and overflow flags, a hardware set beats a software clear
    if (wr_run) begin
      next_st.t1_run_bit       = i_sfr_wdata[mtb_pkg::BIT_T1_RUN];
      next_st.t0_run_bit       = i_sfr_wdata[mtb_pkg::BIT_T0_RUN];
      next_st.t1_overflow_flag = i_sfr_wdata[mtb_pkg::BIT_T1_OVF];
      next_st.t0_overflow_flag = i_sfr_wdata[mtb_pkg::BIT_T0_OVF];
    end
    if (set_ovf1) begin
      next_st.t1_overflow_flag = 1'b1;
    end
    if (set_ovf0) begin
      next_st.t0_overflow_flag = 1'b1;
    end

    // Mode fields
    if (wr_mode) begin
      next_st.timer1_mode_field = mtb_pkg::mtb_mode_t'(
        i_sfr_wdata[mtb_pkg::BIT_T1_MODE +: 2]);
      next_st.timer0_mode_field = mtb_pkg::mtb_mode_t'(
        i_sfr_wdata[mtb_pkg::BIT_T0_MODE +: 2]);
    end

    // Long timer prescaler and count
    if (lt_step) begin
      next_st.lt_prescale = mtb_pkg::RST_COUNT;
      next_st.lt_count    = st.lt_count + 16'h0001;
    end else if (st.long_timer_enable && slow_tick) begin
      next_st.lt_prescale = st.lt_prescale + 16'h0001;
    end
    if (lt_done) begin
      next_st.lt_count = mtb_pkg::RST_COUNT;
      if (!st.long_timer_reload_mode) begin
        next_st.long_timer_enable = 1'b0;
      end
    end

    // Long timer configuration and target
    if (wr_cfg) begin
      next_st.long_timer_step_mode    =
        i_sfr_wdata[mtb_pkg::BIT_LT_STEP];
      next_st.long_timer_clock_choice =
        i_sfr_wdata[mtb_pkg::BIT_LT_CLOCK];
      next_st.long_timer_reload_mode  =
        i_sfr_wdata[mtb_pkg::BIT_LT_RELOAD];
      next_st.long_timer_enable       =
        i_sfr_wdata[mtb_pkg::BIT_LT_ENABLE];
    end
    if (wr_tgt_h) begin
      next_st.long_timer_target_high = i_sfr_wdata;
    end
    if (wr_tgt_l) begin
      next_st.long_timer_target_low = i_sfr_wdata;
    end
    if (lt_restart) begin
      next_st.lt_count    = mtb_pkg::RST_COUNT;
      next_st.lt_prescale = mtb_pkg::RST_COUNT;
    end

    // Completion status: clear by write of 0 or config write, set wins
    if ((wr_stat && !i_sfr_wdata[mtb_pkg::BIT_LT_IRQ]) || wr_cfg) begin
      next_st.long_timer_irq_flag = 1'b0;
    end
    if (lt_done) begin
      next_st.long_timer_irq_flag = 1'b1;
    end

    // Registered read data, unmapped addresses read zero
    if (i_sfr_rd) begin
      unique case (i_sfr_addr)
        mtb_pkg::OFS_IRQ_STATUS:
          next_st.rdata = {7'h00, st.long_timer_irq_flag};
        mtb_pkg::OFS_RUN_FLAGS:
          next_st.rdata = {st.t1_overflow_flag, st.t1_run_bit,
                           st.t0_overflow_flag, st.t0_run_bit, 4'h0};
        mtb_pkg::OFS_MODE_SELECT:
          next_st.rdata = {2'h0, st.timer1_mode_field,
                           2'h0, st.timer0_mode_field};
        mtb_pkg::OFS_CNT0_LOW:    next_st.rdata = st.cnt0_low;
        mtb_pkg::OFS_CNT1_LOW:    next_st.rdata = st.cnt1_low;
        mtb_pkg::OFS_CNT0_HIGH:   next_st.rdata = st.cnt0_high;
        mtb_pkg::OFS_CNT1_HIGH:   next_st.rdata = st.cnt1_high;
        mtb_pkg::OFS_LT_CONFIG:
          next_st.rdata = {4'h0, st.long_timer_step_mode,
                           st.long_timer_clock_choice,
                           st.long_timer_reload_mode,
                           st.long_timer_enable};
        mtb_pkg::OFS_LT_TGT_HIGH: next_st.rdata = st.long_timer_target_high;
        mtb_pkg::OFS_LT_TGT_LOW:  next_st.rdata = st.long_timer_target_low;
        default:                  next_st.rdata = mtb_pkg::RST_BYTE;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{
        cnt0_low:                mtb_pkg::RST_BYTE,
        cnt0_high:               mtb_pkg::RST_BYTE,
        cnt1_low:                mtb_pkg::RST_BYTE,
        cnt1_high:               mtb_pkg::RST_BYTE,
        timer1_mode_field:       mtb_pkg::MODE_13BIT,
        timer0_mode_field:       mtb_pkg::MODE_13BIT,
        long_timer_target_high:  mtb_pkg::RST_BYTE,
        long_timer_target_low:   mtb_pkg::RST_BYTE,
        lt_count:                mtb_pkg::RST_COUNT,
        lt_prescale:             mtb_pkg::RST_COUNT,
        sync_rc:                 mtb_pkg::RST_SYNC,
        sync_watch_crystal_source:               mtb_pkg::RST_SYNC,
        rdata:                   mtb_pkg::RST_BYTE,
        default:                 1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign o_sfr_rdata           = st.rdata;
  assign o_t0_overflow_flag    = st.t0_overflow_flag;
  assign o_t1_overflow_flag    = st.t1_overflow_flag;
  assign o_long_timer_irq_flag = st.long_timer_irq_flag;

endmodule

//--- logic/mtb_pkg.sv
/*
  Package of the timer block: register offsets, field positions, reset
  values, the timer mode encoding and the structs that carry state.
  Assumes an 8-bit special-function-register bus with byte addresses.
*/
package mtb_pkg;

  // Register offsets on the special-function-register bus
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h85;
  localparam logic [7:0] OFS_RUN_FLAGS   = 8'h88;
  localparam logic [7:0] OFS_MODE_SELECT = 8'h89;
  localparam logic [7:0] OFS_CNT0_LOW    = 8'h8A;
  localparam logic [7:0] OFS_CNT1_LOW    = 8'h8B;
  localparam logic [7:0] OFS_CNT0_HIGH   = 8'h8C;
  localparam logic [7:0] OFS_CNT1_HIGH   = 8'h8D;
  localparam logic [7:0] OFS_LT_CONFIG   = 8'h93;
  localparam logic [7:0] OFS_LT_TGT_HIGH = 8'h94;
  localparam logic [7:0] OFS_LT_TGT_LOW  = 8'h95;

  // Field positions in timer_run_flags
  localparam int BIT_T1_OVF = 7;
  localparam int BIT_T1_RUN = 6;
  localparam int BIT_T0_OVF = 5;
  localparam int BIT_T0_RUN = 4;

  // Field positions in timer_mode_select (low bit of each field)
  localparam int BIT_T1_MODE = 4;
  localparam int BIT_T0_MODE = 0;

  // Field positions in long_timer_config
  localparam int BIT_LT_STEP   = 3;
  localparam int BIT_LT_CLOCK  = 2;
  localparam int BIT_LT_RELOAD = 1;
  localparam int BIT_LT_ENABLE = 0;

  // Field position in timer_irq_status
  localparam int BIT_LT_IRQ = 0;

  // Reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [2:0]  RST_SYNC  = 3'h0;

  // Slow clock edges in one long step when the step mode bit is set
  localparam int LT_STEP_EDGES = 65536;

  // Timer 0/1 mode encoding
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT8
  } mtb_mode_t;

  // Result of one count step of a classic timer
  typedef struct packed {
    logic       ovf;
    logic [7:0] low;
    logic [7:0] high;
  } mtb_step_t;

  // Whole state of the block
  typedef struct packed {
    logic [7:0]  cnt0_low;
    logic [7:0]  cnt0_high;
    logic [7:0]  cnt1_low;
    logic [7:0]  cnt1_high;
    logic        t1_overflow_flag;
    logic        t1_run_bit;
    logic        t0_overflow_flag;
    logic        t0_run_bit;
    mtb_mode_t   timer1_mode_field;
    mtb_mode_t   timer0_mode_field;
    logic        long_timer_step_mode;
    logic        long_timer_clock_choice;
    logic        long_timer_reload_mode;
    logic        long_timer_enable;
    logic        long_timer_irq_flag;
    logic [7:0]  long_timer_target_high;
    logic [7:0]  long_timer_target_low;
    logic [15:0] lt_count;
    logic [15:0] lt_prescale;
    logic [2:0]  sync_rc;
    logic [2:0]  sync_watch_crystal_source;
    logic        stable_rc;
    logic        stable_watch_crystal_source;
    logic [7:0]  rdata;
  } mtb_state_t;

endpackage

//--- bench/mtb_timer_block_properties.sv
/*
  Port checker of the timer block: read-back masks, read data hold and
  flag behaviour after stop writes.
  Assumes binding into every timer block instance.
*/
`timescale 1ns/100ps
module mtb_timer_block_properties (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  // Register bus
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  // Event levels
  input wire logic       o_t0_overflow_flag,
  input wire logic       o_t1_overflow_flag,
  input wire logic       o_long_timer_irq_flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Read-back of places and masks
  property p_unmapped;
    i_sfr_rd && !(i_sfr_addr inside {8'h85, [8'h88:8'h8D], [8'h93:8'h95]})
      |=> o_sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_run_flags;
    i_sfr_rd && i_sfr_addr == 8'h88 |=> o_sfr_rdata[3:0] == 4'h0 &&
      o_sfr_rdata[5] == $past(o_t0_overflow_flag) &&
      o_sfr_rdata[7] == $past(o_t1_overflow_flag);
  endproperty
  a_run_flags: assert property (p_run_flags)
    else $error("run flags read wrong");
  property p_mode_mask;
    i_sfr_rd && i_sfr_addr == 8'h89 |=> o_sfr_rdata[7:6] == 2'b00 &&
      o_sfr_rdata[3:2] == 2'b00;
  endproperty
  a_mode_mask: assert property (p_mode_mask)
    else $error("mode reserved bits set");
  property p_mode_wr_rd;
    (i_sfr_wr && i_sfr_addr == 8'h89) ##1
      (i_sfr_rd && !i_sfr_wr && i_sfr_addr == 8'h89)
      |=> o_sfr_rdata == ($past(i_sfr_wdata, 2) & 8'h33);
  endproperty
  a_mode_wr_rd: assert property (p_mode_wr_rd)
    else $error("mode read-back wrong");
  property p_cfg_mask;
    i_sfr_rd && i_sfr_addr == 8'h93 |=> o_sfr_rdata[7:4] == 4'h0;
  endproperty
  a_cfg_mask: assert property (p_cfg_mask)
    else $error("config reserved bits set");
  property p_irq_read;
    i_sfr_rd && i_sfr_addr == 8'h85
      |=> o_sfr_rdata == {7'h00, $past(o_long_timer_irq_flag)};
  endproperty
  a_irq_read: assert property (p_irq_read)
    else $error("status read wrong");
  property p_rdata_hold;
    !i_sfr_rd |=> $stable(o_sfr_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without read");

  // Stopped timers raise no flag
  property p_t0_stop;
    (i_sfr_wr && i_sfr_addr == 8'h88 && i_sfr_wdata[6:4] == 3'b000) ##1
      !(i_sfr_wr && i_sfr_addr == 8'h88) |=> $stable(o_t0_overflow_flag);
  endproperty
  a_t0_stop: assert property (p_t0_stop)
    else $error("timer 0 flag moved while stopped");
  property p_t1_stop;
    (i_sfr_wr && i_sfr_addr == 8'h88 && i_sfr_wdata[6:4] == 3'b000) ##1
      !(i_sfr_wr && i_sfr_addr == 8'h88) |=> $stable(o_t1_overflow_flag);
  endproperty
  a_t1_stop: assert property (p_t1_stop)
    else $error("timer 1 flag moved while stopped");
  property p_irq_off;
    (i_sfr_wr && i_sfr_addr == 8'h93 && !i_sfr_wdata[0]) ##1
      !(i_sfr_wr && i_sfr_addr inside {8'h85, 8'h93})
      |=> $stable(o_long_timer_irq_flag);
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("status moved with long timer off");

  // Main events seen
  c_t0_ovf: cover property ($rose(o_t0_overflow_flag));
  c_t1_ovf: cover property ($rose(o_t1_overflow_flag));
  c_irq: cover property ($rose(o_long_timer_irq_flag));
endmodule

bind mtb_timer_block mtb_timer_block_properties
  mtb_timer_block_properties_i (.*);

//--- bench/mtb_timer_block_bench.sv
/*
  Self-checking bench of the timer block: integer model of the counters
  compared at every read, fixed expected values for the long timer.
  Assumes the package, the design and the bound checker are compiled.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module mtb_timer_block_bench;
  localparam int STEP = 4;
  logic        i_clk, i_rst_n, i_sfr_wr, i_sfr_rd;
  logic [7:0]  i_sfr_addr, i_sfr_wdata, o_sfr_rdata, v;
  logic        i_slow_rc_source, i_watch_crystal_source;
  logic        o_t0_overflow_flag, o_t1_overflow_flag, o_long_timer_irq_flag;
  logic [31:0] seed = 32'h9f4d_f6f8;
  int          miscompares = 0, n_tests = 0;
  int          lo, hi, f, f0, f1, z, k;
  logic [7:0]  regs [11] = '{8'h85, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C,
                             8'h8D, 8'h93, 8'h94, 8'h95, 8'h80};

  mtb_timer_block #(.P_STEP_EDGES(STEP)) mtb_timer_block_i (.*);

  // Clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Pseudo-random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // One count step of a classic timer
  function automatic void tstep(input int m, inout int a, inout int b,
                                inout int g);
    int c;
    c = (m == 0) ? b * 32 + a % 32 + 1 : b * 256 + a + 1;
    if (m == 0) begin
      g = (c == 8192) ? 1 : g;
      b = (c / 32) % 256;
      a = a / 32 * 32 + c % 32;
    end else if (m == 1) begin
      g = (c == 65536) ? 1 : g;
      b = (c / 256) % 256;
      a = c % 256;
    end else begin
      g = (a == 255) ? 1 : g;
      a = (a == 255) ? ((m == 2) ? b : 0) : a + 1;
    end
  endfunction

  // One bus cycle, driven just after the edge
  task automatic bus(input logic w, r, input logic [7:0] a, d);
    @(posedge i_clk);
    #1;
    i_sfr_wr = w;
    i_sfr_rd = r;
    i_sfr_addr = a;
    i_sfr_wdata = d;
  endtask

  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    d = o_sfr_rdata;
  endtask

  // Rising edges on the crystal pin or the RC pin
  task automatic slow(input logic x, input int n);
    repeat (n) begin
      repeat (8) bus(1'b0, 1'b0, 8'h00, 8'h00);
      {i_watch_crystal_source, i_slow_rc_source} = x ? 2'b10 : 2'b01;
      repeat (8) bus(1'b0, 1'b0, 8'h00, 8'h00);
      {i_watch_crystal_source, i_slow_rc_source} = 2'b00;
    end
  endtask

  task automatic results();
    $display("TB: tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Run limit
  initial begin
    repeat (100000) @(posedge i_clk);
    miscompares++;
    $display("MISMATCH %0t run limit reached", $time);
    results();
  end

  // Main sequence
  initial begin
    {i_rst_n, i_sfr_wr, i_sfr_rd, i_sfr_addr, i_sfr_wdata} = '0;
    {i_slow_rc_source, i_watch_crystal_source} = 2'b00;
    repeat (20) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    foreach (regs[j]) begin
      rd(regs[j], v);
      `CHK(v, 8'h00)
    end
    wr(8'h80, 8'hA5);
    rd(8'h80, v);
    `CHK(v, 8'h00)
    wr(8'h89, 8'hFF);
    rd(8'h89, v);
    `CHK(v, 8'h33)
    // Every mode of both timers from a random low byte, high byte 255 except in mode 2
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 4; m++) begin
        lo = int'(xs() % 32'd256);
        hi = (m == 2) ? int'(xs() % 32'd256) : 255;
        k = 20 + int'(xs() % 32'd40);
        {f, f0, f1} = '0;
        wr(8'h88, 8'h00);
        wr(8'h89, 8'((t == 0) ? m : m * 16));
        wr(8'(8'h8A + t), 8'(lo));
        wr(8'(8'h8C + t), 8'(hi));
        wr(8'h88, (t == 1) ? 8'h40 : ((m == 3) ? 8'h50 : 8'h10));
        repeat (k - 1) bus(1'b0, 1'b0, 8'h00, 8'h00);
        wr(8'h88, 8'h00);
        // Flags seen before the stop write lands, which clears them
        // unless the final step sets them again
        for (int i = 0; i < k; i++) begin
          if (i == k - 1) begin
            f0 = (t == 0) ? f : 0;
            f1 = (t == 1) ? f : f1;
            `CHK(o_t0_overflow_flag, 1'(f0))
            `CHK(o_t1_overflow_flag, 1'(f1))
            {f, f1} = '0;
          end
          if (t == 0 || m != 3) tstep(m, lo, hi, f);
          if (t == 0 && m == 3) tstep(3, hi, z, f1);
        end
        if (t == 0) f0 = f;
        else f1 = f;
        rd(8'(8'h8A + t), v);
        `CHK(v, 8'(lo))
        rd(8'(8'h8C + t), v);
        `CHK(v, 8'(hi))
        rd(8'h88, v);
        `CHK(v, 8'(f1 * 128 + f0 * 32))
        `CHK(o_t0_overflow_flag, 1'(f0))
        `CHK(o_t1_overflow_flag, 1'(f1))
      end
    end
    // Long timer, manual then automatic reload
    wr(8'h94, 8'h00);
    wr(8'h95, 8'h03);
    wr(8'h93, 8'h01);
    slow(1'b0, 3);
    `CHK(o_long_timer_irq_flag, 1'b0)
    slow(1'b0, 1);
    `CHK(o_long_timer_irq_flag, 1'b1)
    rd(8'h93, v);
    `CHK(v, 8'h00)
    wr(8'h85, 8'h01);
    rd(8'h85, v);
    `CHK(v, 8'h01)
    wr(8'h85, 8'h00);
    rd(8'h85, v);
    `CHK(v, 8'h00)
    wr(8'h93, 8'h03);
    slow(1'b0, 2);
    wr(8'h93, 8'h03);
    slow(1'b0, 3);
    `CHK(o_long_timer_irq_flag, 1'b0)
    slow(1'b0, 1);
    `CHK(o_long_timer_irq_flag, 1'b1)
    rd(8'h93, v);
    `CHK(v, 8'h03)
    wr(8'h93, 8'h03);
    rd(8'h85, v);
    `CHK(v, 8'h00)
    slow(1'b0, 2);
    wr(8'h95, 8'h03);
    slow(1'b0, 3);
    `CHK(o_long_timer_irq_flag, 1'b0)
    slow(1'b0, 1);
    `CHK(o_long_timer_irq_flag, 1'b1)
    // Long step, then the crystal source
    wr(8'h93, 8'h09);
    wr(8'h95, 8'h01);
    slow(1'b0, 2 * STEP - 1);
    `CHK(o_long_timer_irq_flag, 1'b0)
    slow(1'b0, 1);
    `CHK(o_long_timer_irq_flag, 1'b1)
    wr(8'h93, 8'h05);
    slow(1'b0, 4);
    `CHK(o_long_timer_irq_flag, 1'b0)
    slow(1'b1, 2);
    `CHK(o_long_timer_irq_flag, 1'b1)
    wr(8'h93, 8'h00);
    rd(8'h85, v);
    `CHK(v, 8'h00)
    // Target bytes read back while the long timer is off
    lo = int'(xs() % 32'd256);
    wr(8'h94, 8'(lo));
    rd(8'h94, v);
    `CHK(v, 8'(lo))
    rd(8'h95, v);
    `CHK(v, 8'h01)
    results();
  end
endmodule
